// *** rtl/pks_pkg.sv ***
// Purpose: shared constants and types for the front panel key and status logic
// Assumes: 100 MHz ref_clk
// Notes: state codes are indices into the display driver, not segment patterns
`default_nettype none
package pks_pkg;
   localparam int CLK_MHZ = 100;
   localparam int DEBOUNCE_US = 10000; // key settle time
   localparam int HOLD_MS = 1000; // alarm clear hold time
   localparam int BLINK_MS = 500; // alarm blink half period
   localparam int DEBOUNCE_CYC = DEBOUNCE_US * CLK_MHZ;
   localparam int HOLD_CYC = HOLD_MS * 1000 * CLK_MHZ;
   localparam int BLINK_CYC = BLINK_MS * 1000 * CLK_MHZ;
   localparam int NUM_FUNCS = 4; // display functions in the cycle
   localparam int NUM_DIGITS = 5; // editable digits
   localparam logic [15:0] VALUE_RST = 16'h0000;
   localparam logic [15:0] VALUE_STEP = 16'h0001;
   // state display codes
   typedef enum logic [2:0] {
      PKS_ST_READY, PKS_ST_RUN, PKS_ST_FWD_OT, PKS_ST_REV_OT,
      PKS_ST_NOT_READY, PKS_ST_ALARM
   } pks_state_code_t;
endpackage
`default_nettype wire

// *** rtl/pks_panel.sv ***
// Purpose: key decoding, value editing and status display for the drive panel
// Assumes: keys and status inputs are asynchronous pins, active high
// Notes: one always_comb and one always_ff over a single state struct
`timescale 1ns/1ps
`default_nettype none
module pks_panel #(
   parameter int DEBOUNCE_CYCLES = pks_pkg::DEBOUNCE_CYC,
   parameter int HOLD_CYCLES = pks_pkg::HOLD_CYC,
   parameter int BLINK_CYCLES = pks_pkg::BLINK_CYC
) (
   input wire logic ref_clk,
   input wire logic srst,
   input wire logic key_mode,
   input wire logic key_up,
   input wire logic key_down,
   input wire logic key_data,
   input wire logic alarm_active,
   input wire logic [7:0] alarm_number,
   input wire logic control_power_ok,
   input wire logic main_circuit_ok,
   input wire logic encoder_ok,
   input wire logic drive_enabled,
   input wire logic forward_overtravel_input,
   input wire logic reverse_overtravel_input,
   input wire logic position_mode,
   input wire logic speed_match_flag,
   input wire logic in_position_flag,
   output logic [2:0] state_code,
   output logic [7:0] alarm_digits,
   output logic alarm_blank,
   output logic alarm_clear,
   output logic [1:0] func_sel,
   output logic editing,
   output logic [15:0] value,
   output logic [2:0] edit_digit,
   output logic seg_control_power,
   output logic seg_ready,
   output logic seg_enable,
   output logic seg_match
);
   localparam int NK = 4; // keys: 0 mode, 1 up, 2 down, 3 data
   localparam int NS = 10; // status pins and alarm state
   localparam int DW = $clog2(DEBOUNCE_CYCLES + 1);
   localparam int HW = $clog2(HOLD_CYCLES + 1);
   localparam int BW = $clog2(BLINK_CYCLES + 1);

   typedef struct packed {
      logic [NK-1:0] k1, k2, kdb;
      logic [NK-1:0][DW-1:0] kcnt;
      logic [NS-1:0] s1, s2;
      logic [HW-1:0] hold;
      logic clr_done;
      logic [BW-1:0] blink_cnt;
      logic blink;
      logic [1:0] func;
      logic edit;
      logic [15:0] val;
      logic [2:0] digit;
      logic [2:0] code;
      logic [7:0] alm1, alm;
      logic blank, clr, seg_cp, seg_rdy, seg_en, seg_m;
   } pks_st_t;

   pks_st_t st, next_st;

   // one unit in the nibble of the edited digit; the fifth digit wraps to 0
   function automatic logic [15:0] pks_digit_step(input logic [2:0] d);
      pks_digit_step = pks_pkg::VALUE_STEP << {d[1:0], 2'h0};
   endfunction

   logic [NK-1:0] press;
   logic [NS-1:0] spin, ss;
   pks_pkg::pks_state_code_t c;

   assign spin = {alarm_active, in_position_flag, speed_match_flag,
                  position_mode,
                  reverse_overtravel_input, forward_overtravel_input,
                  drive_enabled, encoder_ok, main_circuit_ok, control_power_ok};

   // next state: sync, debounce, key actions, status decode
   always_comb begin
      next_st = st;
      press = '0;
      next_st.k1 = {key_data, key_down, key_up, key_mode};
      next_st.k2 = st.k1;
      next_st.s1 = spin;
      next_st.s2 = st.s1;
      ss = st.s2;
      for (int i = 0; i < NK; i++) begin
         if (st.k2[i] == st.kdb[i]) begin
            next_st.kcnt[i] = '0;
         end else if (st.kcnt[i] == DW'(DEBOUNCE_CYCLES - 1)) begin
            next_st.kcnt[i] = '0;
            next_st.kdb[i] = st.k2[i];
            press[i] = st.k2[i];
         end else begin
            next_st.kcnt[i] = st.kcnt[i] + DW'(1);
         end
      end
      // both up and down held: qualify, then clear once
      next_st.clr = 1'b0;
      if (st.kdb[1] && st.kdb[2]) begin
         if (st.hold == HW'(HOLD_CYCLES - 1)) begin
            if (!st.clr_done) begin
               next_st.clr = 1'b1;
            end
            next_st.clr_done = 1'b1;
         end else begin
            next_st.hold = st.hold + HW'(1);
         end
      end else begin
         next_st.hold = '0;
         next_st.clr_done = 1'b0;
      end
      // key actions; arrow steps suppressed while the other arrow key is held
      if (press[0]) begin
         if (st.edit) begin
            next_st.edit = 1'b0;
         end else if (st.func == 2'(pks_pkg::NUM_FUNCS - 1)) begin
            next_st.func = '0;
         end else begin
            next_st.func = st.func + 2'h1;
         end
      end else if (press[1] && !press[2] && !st.kdb[2] && st.edit) begin
         next_st.val = st.val + pks_digit_step(st.digit);
      end else if (press[2] && !press[1] && !st.kdb[1] && st.edit) begin
         next_st.val = st.val - pks_digit_step(st.digit);
      end else if (press[3]) begin
         if (!st.edit) begin
            next_st.edit = 1'b1;
            next_st.digit = '0;
         end else if (st.digit == 3'(pks_pkg::NUM_DIGITS - 1)) begin
            next_st.digit = '0;
         end else begin
            next_st.digit = st.digit + 3'h1;
         end
      end
      // blink timer for the alarm number
      if (st.blink_cnt == BW'(BLINK_CYCLES - 1)) begin
         next_st.blink_cnt = '0;
         next_st.blink = !st.blink;
      end else begin
         next_st.blink_cnt = st.blink_cnt + BW'(1);
      end
      // state code by priority
      if (ss[9]) begin
         c = pks_pkg::PKS_ST_ALARM;
      end else if (!(ss[1] && ss[2])) begin
         c = pks_pkg::PKS_ST_NOT_READY;
      end else if (ss[4]) begin
         c = pks_pkg::PKS_ST_FWD_OT;
      end else if (ss[5]) begin
         c = pks_pkg::PKS_ST_REV_OT;
      end else if (ss[3]) begin
         c = pks_pkg::PKS_ST_RUN;
      end else begin
         c = pks_pkg::PKS_ST_READY;
      end
      next_st.code = c;
      next_st.alm1 = alarm_number;
      next_st.alm = st.alm1;
      next_st.blank = ss[9] && st.blink;
      next_st.seg_cp = ss[0];
      next_st.seg_rdy = ss[0] && ss[1] && ss[2] && !ss[9];
      next_st.seg_en = ss[3];
      next_st.seg_m = ss[6] ? ss[8] : ss[7];
      if (srst) begin
         next_st = '0;
         next_st.val = pks_pkg::VALUE_RST;
      end
   end

   // state register
   always_ff @(posedge ref_clk) begin
      st <= next_st;
   end

   assign state_code = st.code;
   assign alarm_digits = st.alm;
   assign alarm_blank = st.blank;
   assign alarm_clear = st.clr;
   assign func_sel = st.func;
   assign editing = st.edit;
   assign value = st.val;
   assign edit_digit = st.digit;
   assign seg_control_power = st.seg_cp;
   assign seg_ready = st.seg_rdy;
   assign seg_enable = st.seg_en;
   assign seg_match = st.seg_m;

   // alarm overrides every other code
   alarm_code_a: assert property (@(posedge ref_clk)
      disable iff (srst)
      st.s2[9] |=> state_code == 3'(pks_pkg::PKS_ST_ALARM))
      else $error("alarm code not shown");
   // clear pulse only after both keys debounced-held
   clear_hold_a: assert property (@(posedge ref_clk)
      disable iff (srst)
      alarm_clear |-> $past(st.kdb[1]) && $past(st.kdb[2]))
      else $error("clear without both keys held");
   clear_pulse_a: assert property (@(posedge ref_clk)
      disable iff (srst)
      alarm_clear |=> !alarm_clear)
      else $error("clear longer than one cycle");
   func_step_a: assert property (@(posedge ref_clk) disable iff (srst)
      press[0] && !editing |=> func_sel == $past(func_sel) + 2'h1)
      else $error("mode press did not advance");
   up_step_a: assert property (@(posedge ref_clk) disable iff (srst)
      press[1] && !press[0] && !press[2] && !st.kdb[2] && editing
      |=> value == $past(value) + pks_digit_step($past(edit_digit)))
      else $error("increment wrong");
   down_step_a: assert property (@(posedge ref_clk) disable iff (srst)
      press[2] && !press[0] && !press[1] && !st.kdb[1] && editing
      |=> value == $past(value) - pks_digit_step($past(edit_digit)))
      else $error("decrement wrong");
   enable_seg_a: assert property (@(posedge ref_clk)
      disable iff (srst)
      $rose(drive_enabled) |-> ##[3:4] seg_enable)
      else $error("enable segment late");
   power_seg_a: assert property (@(posedge ref_clk) disable iff (srst)
      $fell(control_power_ok) |-> ##[3:4] !seg_control_power)
      else $error("power segment stuck");
   fwd_ot_a: assert property (@(posedge ref_clk) disable iff (srst)
      !st.s2[9] && st.s2[2:1] == 2'h3 && st.s2[4]
      |=> state_code == 3'(pks_pkg::PKS_ST_FWD_OT))
      else $error("forward overtravel code missing");
endmodule // pks_panel
`default_nettype wire

// *** sim/pks_operator.sv ***
// Purpose: operator model pressing the front panel keys
// Assumes: key pins are high while pressed
// Notes: each press is held, then released long enough to debounce
`timescale 1ns/1ps
`default_nettype none
module pks_operator (
   input wire logic ref_clk,
   output var logic key_mode,
   output var logic key_up,
   output var logic key_down,
   output var logic key_data
);
   initial begin
      {key_mode, key_up, key_down, key_data} = 4'h0;
   end
   // hold the chosen keys, release them, settle before returning
   task automatic press(input logic [3:0] keys, input int hold);
      @(posedge ref_clk);
      {key_mode, key_up, key_down, key_data} <= keys;
      repeat (hold) @(posedge ref_clk);
      {key_mode, key_up, key_down, key_data} <= 4'h0;
      repeat (12) @(posedge ref_clk);
      @(negedge ref_clk);
   endtask
endmodule // pks_operator
`default_nettype wire

// *** sim/test_pks_panel.sv ***
// Purpose: self-checking bench for the panel key and status logic
// Assumes: short debounce, hold and blink counts
// Notes: status pins come from one packed vector stepped through a table
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e) begin checks++; if ((a) !== (e)) begin failures++; \
   $display("mismatch t=%0t got %h exp %h", $time, (a), (e)); end end
module test_pks_panel;
   logic ref_clk = 1'b0;
   logic srst = 1'b1;
   logic [9:0] st = 10'h000;
   logic [7:0] alarm_number = 8'h2a;
   logic key_mode, key_up, key_down, key_data;
   logic [2:0] state_code, edit_digit;
   logic [7:0] alarm_digits, clears = 8'h00;
   logic alarm_blank, alarm_clear, editing, b;
   logic [1:0] func_sel;
   logic [15:0] value;
   logic seg_control_power, seg_ready, seg_enable, seg_match;
   int failures = 0;
   int checks = 0;
   // {position mode, speed match, in position, alarm, ctrl power,
   //  main ok, encoder ok, enabled, fwd open, rev open} -> expectation
   logic [9:0] stv [7] = '{10'h138, 10'h03c, 10'h2be, 10'h33d, 10'h028,
      10'h018, 10'h078};
   logic [6:0] exv [7] = '{7'h0d, 7'h1e, 7'h2f, 7'h3e, 7'h48, 7'h00, 7'h58};
   always #5 ref_clk = ~ref_clk;
   // count clear pulses
   always @(posedge ref_clk) begin
      if (alarm_clear === 1'b1) clears <= clears + 8'h01;
   end
   pks_operator pks_operator_inst (.ref_clk(ref_clk), .key_mode(key_mode),
      .key_up(key_up), .key_down(key_down), .key_data(key_data));
   pks_panel #(.DEBOUNCE_CYCLES(4), .HOLD_CYCLES(20), .BLINK_CYCLES(8))
   pks_panel_inst (.ref_clk(ref_clk), .srst(srst), .key_mode(key_mode),
      .key_up(key_up), .key_down(key_down), .key_data(key_data),
      .alarm_active(st[6]), .alarm_number(alarm_number),
      .control_power_ok(st[5]), .main_circuit_ok(st[4]),
      .encoder_ok(st[3]), .drive_enabled(st[2]),
      .forward_overtravel_input(st[1]), .reverse_overtravel_input(st[0]),
      .position_mode(st[9]), .speed_match_flag(st[8]),
      .in_position_flag(st[7]), .state_code(state_code),
      .alarm_digits(alarm_digits), .alarm_blank(alarm_blank),
      .alarm_clear(alarm_clear), .func_sel(func_sel), .editing(editing),
      .value(value), .edit_digit(edit_digit),
      .seg_control_power(seg_control_power), .seg_ready(seg_ready),
      .seg_enable(seg_enable), .seg_match(seg_match));
   // print counts and verdict, end the run
   task automatic wrap_up();
      $display("checks %0d failures %0d", checks, failures);
      if (failures == 0 && checks > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask
   // watchdog against a hang
   initial begin
      #50000;
      failures++;
      wrap_up();
   end
   // main sequence
   initial begin
      repeat (2) @(posedge ref_clk);
      srst <= 1'b0;
      @(negedge ref_clk);
      `CHK(func_sel, 2'h0)
      `CHK(value, 16'h0000)
      $display("test reset done");
      pks_operator_inst.press(4'h8, 12);
      `CHK(func_sel, 2'h1)
      repeat (3) pks_operator_inst.press(4'h8, 12);
      `CHK(func_sel, 2'h0)
      pks_operator_inst.press(4'h4, 12);
      `CHK(value, 16'h0000)
      pks_operator_inst.press(4'h1, 12);
      `CHK({editing, edit_digit}, 4'h8)
      repeat (2) pks_operator_inst.press(4'h4, 12);
      `CHK(value, 16'h0002)
      pks_operator_inst.press(4'h2, 12);
      `CHK(value, 16'h0001)
      pks_operator_inst.press(4'h1, 12);
      `CHK(edit_digit, 3'h1)
      pks_operator_inst.press(4'h4, 12);
      `CHK(value, 16'h0011)
      repeat (3) pks_operator_inst.press(4'h1, 12);
      `CHK(edit_digit, 3'h4)
      pks_operator_inst.press(4'h1, 12);
      `CHK(edit_digit, 3'h0)
      pks_operator_inst.press(4'h8, 12);
      `CHK({editing, func_sel, value}, 19'h00011)
      $display("test keys done");
      for (int i = 0; i < 7; i++) begin
         @(posedge ref_clk);
         st <= stv[i];
         repeat (5) @(posedge ref_clk);
         @(negedge ref_clk);
         `CHK(state_code, exv[i][6:4])
         `CHK({seg_control_power, seg_ready, seg_enable, seg_match},
            exv[i][3:0])
      end
      $display("test status done");
      `CHK(alarm_digits, 8'h2a)
      b = alarm_blank;
      repeat (8) @(posedge ref_clk);
      @(negedge ref_clk);
      `CHK(alarm_blank, ~b)
      pks_operator_inst.press(4'h6, 30);
      `CHK(clears, 8'h01)
      // both arrows pressed together while editing: no step, too short to clear
      pks_operator_inst.press(4'h1, 12);
      pks_operator_inst.press(4'h6, 12);
      `CHK({editing, value}, 17'h10011)
      `CHK(clears, 8'h01)
      $display("test alarm done");
      wrap_up();
   end
endmodule // test_pks_panel
`default_nettype wire
